/* hw/ssr_pkg.sv */
package ssr_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam int unsigned REG_AW      = 4;
  localparam logic [3:0]  OFF_CTRL    = 4'h0;
  localparam logic [3:0]  OFF_STATUS  = 4'h4;
  localparam logic [3:0]  OFF_BURST   = 4'h8;
  localparam logic [3:0]  OFF_WCOUNT  = 4'hC;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_DECERR = 2'h3;

  // control bits
  localparam int unsigned CTRL_SLEEP  = 0;
  localparam int unsigned CTRL_CLR    = 1;

  // ----------------------------------------------------------------
  // strap vector layout, also the low bits of the status word
  // ----------------------------------------------------------------
  localparam int unsigned STRAP_W      = 5;
  localparam int unsigned STRAP_ORDER  = 0;
  localparam int unsigned STRAP_FLOW   = 1;
  localparam int unsigned STRAP_SDESEL = 2;
  localparam int unsigned STRAP_DRIVE  = 3;
  localparam int unsigned STRAP_SLEEP  = 4;
  // pull-up levels on order/flow/deselect/drive, pull-down on sleep
  localparam logic [4:0]  STRAP_RST    = 5'h0F;

  localparam int unsigned ST_STANDBY   = 5;
  localparam int unsigned ST_ACTIVE    = 6;
  localparam int unsigned ST_OE        = 7;

  // ----------------------------------------------------------------
  // memory side
  // ----------------------------------------------------------------
  localparam int unsigned LANES     = 4;
  localparam int unsigned CNT_W     = 2;
  localparam logic [3:0]  ALL_LANES = 4'hF;
  localparam logic [3:0]  NO_LANES  = 4'h0;

  typedef enum logic [1:0] {
    CYC_IDLE,
    CYC_READ,
    CYC_WRITE
  } ssr_cyc_e;

endpackage : ssr_pkg

/* hw/ssr_burst_ctr.sv */
`timescale 1ns/1ns
module ssr_burst_ctr
  import ssr_pkg::*;
#(
  parameter int unsigned CW = CNT_W
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          load,
  input  wire logic [CW-1:0] start,
  input  wire logic          advance,
  input  wire logic          interleave,
  output logic      [CW-1:0] addr
);

  typedef struct packed {
    logic [CW-1:0] start;
    logic [CW-1:0] beat;
    logic [CW-1:0] addr;
  } ssr_ctr_s;

  ssr_ctr_s q;
  ssr_ctr_s n;

  always_comb begin
    n = q;
    if (load) begin
      n.start = start; // [R1]
      n.beat  = '0;
    end else if (advance) begin
      // beat index wraps, so the fourth step is back at the start
      n.beat = CW'(q.beat + CW'(1)); // [R2] [R15]
    end
    if (interleave) begin
      n.addr = n.start ^ n.beat; // [R15]
    end else begin
      n.addr = CW'(n.start + n.beat); // [R14]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign addr = q.addr;

endmodule : ssr_burst_ctr

/* hw/ssr_ctrl.sv */
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
// Functional notes
// [R1] strobe loads two low address bits
// [R2] active-low advance steps the counter
// [R3] either strobe starts access at external address
// [R4] disabled lanes keep their contents
// [R5] byte write hits enabled lanes only
// [R6] global write hits every lane
// [R7] order strap low linear, high interleaved
// [R8] flow strap low bypasses output register
// [R9] sleep high forces standby
// [R10] deselect strap low gives dual deselect
// [R11] drive strap low gives high drive
// [R12] mode straps default high when floating
// [R13] sleep defaults low when floating
// [R14] linear order counts modulo four
// [R15] interleaved order xors start with beat
// [R16] all chip enables needed for selection
// [R17] upper address held, replaced per strobe
// [R18] straps are static, sampled continuously
module ssr_ctrl
  import ssr_pkg::*;
#(
  parameter int unsigned ADDR_W = 22
) (
  input  wire logic              CORE_CLK,
  input  wire logic              NRST,
  // register bus
  input  wire logic [REG_AW-1:0] S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  input  wire logic [REG_AW-1:0] S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  // memory bus, synchronous to CORE_CLK
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic              PROC_ADDR_STROBE_N,
  input  wire logic              CTRL_ADDR_STROBE_N,
  input  wire logic              BURST_ADVANCE_N,
  input  wire logic              CHIP_SEL_N,
  input  wire logic              CHIP_SEL_HI,
  input  wire logic              CHIP_SEL3_N,
  input  wire logic              LANE_WRITE_N,
  input  wire logic              ALL_LANES_WRITE_N,
  input  wire logic [LANES-1:0]  LANE_ENABLE_N,
  // straps and sleep, asynchronous
  input  wire logic              LINEAR_ORDER_N,
  input  wire logic              FLOW_THROUGH_N,
  input  wire logic              SINGLE_DESELECT_SEL,
  input  wire logic              DRIVE_STRENGTH_SEL,
  input  wire logic              SLEEP_REQ,
  // array side
  output logic [ADDR_W-1:0]      MEM_ADDR,
  output logic                   MEM_READ,
  output logic                   MEM_WRITE,
  output logic [LANES-1:0]       MEM_LANE_WE,
  output logic                   DATA_OE,
  output logic                   PIPELINED,
  output logic                   DUAL_DESELECT,
  output logic                   HIGH_DRIVE,
  output logic                   STANDBY
);

  typedef struct packed {
    logic [STRAP_W-1:0]     strap_m;
    logic [STRAP_W-1:0]     strap_s;
    logic                   aw_ok;
    logic [REG_AW-1:0]      awaddr;
    logic                   w_ok;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [1:0]             rresp;
    logic [31:0]            rdata;
    logic                   soft_sleep;
    logic                   standby;
    ssr_cyc_e               cyc;
    logic [ADDR_W-1:CNT_W]  upper;
    logic [LANES-1:0]       lane_we;
    logic                   oe_src;
    logic                   oe;
    logic [31:0]            wcount;
  } ssr_state_s;

  localparam ssr_state_s ST_RST = '{
    strap_m: STRAP_RST,
    strap_s: STRAP_RST,
    cyc:     CYC_IDLE,
    default: '0
  };

  ssr_state_s     q;
  ssr_state_s     n;
  logic           ctr_load;
  logic           ctr_adv;
  logic [CNT_W-1:0] ctr_addr;

  // ----------------------------------------------------------------
  // burst address counter
  // ----------------------------------------------------------------
  ssr_burst_ctr #(
    .CW (CNT_W)
  ) u_ctr (
    .clk        (CORE_CLK),
    .rst_n      (NRST),
    .load       (ctr_load),
    .start      (ADDR[CNT_W-1:0]),
    .advance    (ctr_adv),
    .interleave (q.strap_s[STRAP_ORDER]), // [R7]
    .addr       (ctr_addr)
  );

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  function automatic logic [31:0] reg_read(input ssr_state_s s,
                                           input logic [CNT_W-1:0] ca);
    logic [31:0] v;
    v = '0;
    unique case (s.cyc == CYC_IDLE ? 1'b0 : 1'b1)
      1'b0: v[ST_ACTIVE] = 1'b0;
      1'b1: v[ST_ACTIVE] = 1'b1;
    endcase
    v[STRAP_W-1:0] = s.strap_s;
    v[ST_STANDBY]  = s.standby;
    v[ST_OE]       = s.oe;
    return v;
  endfunction : reg_read

  always_comb begin
    logic        standby;
    logic        sel;
    logic        p_start;
    logic        c_start;
    logic        wr_req;
    logic [LANES-1:0] lanes;
    logic        flow;
    logic        dcd;
    logic        aw_hs;
    logic        w_hs;
    standby  = 1'b0;
    sel      = 1'b0;
    p_start  = 1'b0;
    c_start  = 1'b0;
    wr_req   = 1'b0;
    lanes    = NO_LANES;
    flow     = 1'b0;
    dcd      = 1'b0;
    aw_hs    = 1'b0;
    w_hs     = 1'b0;
    n        = q;
    ctr_load = 1'b0;
    ctr_adv  = 1'b0;

    // ----------------------------------------------------------------
    // strap synchronisers; straps are treated as static levels
    // ----------------------------------------------------------------
    n.strap_m = {SLEEP_REQ, DRIVE_STRENGTH_SEL, SINGLE_DESELECT_SEL,
                 FLOW_THROUGH_N, LINEAR_ORDER_N}; // [R18]
    n.strap_s = q.strap_m;
    flow      = ~q.strap_s[STRAP_FLOW];   // [R8]
    dcd       = ~q.strap_s[STRAP_SDESEL]; // [R10]

    // ----------------------------------------------------------------
    // access sequencing
    // ----------------------------------------------------------------
    standby   = q.strap_s[STRAP_SLEEP] | q.soft_sleep; // [R9]
    n.standby = standby;
    sel       = ~CHIP_SEL_N & CHIP_SEL_HI & ~CHIP_SEL3_N; // [R16]
    // processor strobe is ignored while the primary enable is high
    p_start   = ~PROC_ADDR_STROBE_N & ~CHIP_SEL_N; // [R3]
    c_start   = ~CTRL_ADDR_STROBE_N;               // [R3]
    wr_req    = ~ALL_LANES_WRITE_N | ~LANE_WRITE_N;
    if (!ALL_LANES_WRITE_N) begin
      lanes = ALL_LANES; // [R6]
    end else if (!LANE_WRITE_N) begin
      lanes = ~LANE_ENABLE_N; // [R4] [R5]
    end

    if (standby) begin
      n.cyc = CYC_IDLE;
    end else if (p_start || c_start) begin
      if (sel) begin
        ctr_load = 1'b1; // [R1]
        n.upper  = ADDR[ADDR_W-1:CNT_W]; // [R17]
        // a processor strobe always opens a read
        if (!p_start && wr_req) begin
          n.cyc = CYC_WRITE;
        end else begin
          n.cyc = CYC_READ;
        end
      end else begin
        n.cyc = CYC_IDLE; // [R16]
      end
    end else if (q.cyc != CYC_IDLE) begin
      ctr_adv = ~BURST_ADVANCE_N; // [R2]
      n.cyc   = wr_req ? CYC_WRITE : CYC_READ;
    end

    n.lane_we = (n.cyc == CYC_WRITE) ? lanes : NO_LANES; // [R4]

    // flow-through drives in the access cycle, pipelined one later;
    // dual deselect keeps the drivers on for one more cycle
    n.oe_src = flow ? (n.cyc == CYC_READ) : (q.cyc == CYC_READ); // [R8]
    n.oe     = n.oe_src | (dcd & q.oe_src); // [R10]

    // ----------------------------------------------------------------
    // register bus, write side
    // ----------------------------------------------------------------
    aw_hs = S_AXI_AWVALID & ~q.aw_ok & ~q.bvalid;
    w_hs  = S_AXI_WVALID & ~q.w_ok & ~q.bvalid;
    if (aw_hs) begin
      n.aw_ok  = 1'b1;
      n.awaddr = S_AXI_AWADDR;
    end
    if (w_hs) begin
      n.w_ok  = 1'b1;
      n.wdata = S_AXI_WDATA;
      n.wstrb = S_AXI_WSTRB;
    end
    if (q.bvalid && S_AXI_BREADY) begin
      n.bvalid = 1'b0;
    end

    // write beats counted; a clear in the same cycle still keeps it
    if (n.cyc == CYC_WRITE) begin
      n.wcount = q.wcount + 32'h1;
    end

    if (q.aw_ok && q.w_ok) begin
      n.aw_ok  = 1'b0;
      n.w_ok   = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = RESP_OKAY;
      unique case (q.awaddr)
        OFF_CTRL: begin
          if (q.wstrb[0]) begin
            n.soft_sleep = q.wdata[CTRL_SLEEP];
            if (q.wdata[CTRL_CLR]) begin
              n.wcount = (n.cyc == CYC_WRITE) ? 32'h1 : 32'h0;
            end
          end
        end
        OFF_STATUS, OFF_BURST, OFF_WCOUNT: begin
          // read-only words take the write and ignore it
        end
        default: n.bresp = RESP_DECERR;
      endcase
    end

    // ----------------------------------------------------------------
    // register bus, read side
    // ----------------------------------------------------------------
    if (q.rvalid && S_AXI_RREADY) begin
      n.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && !q.rvalid) begin
      n.rvalid = 1'b1;
      n.rresp  = RESP_OKAY;
      n.rdata  = '0;
      unique case (S_AXI_ARADDR)
        OFF_CTRL:   n.rdata[CTRL_SLEEP] = q.soft_sleep;
        OFF_STATUS: n.rdata = reg_read(q, ctr_addr);
        OFF_BURST:  n.rdata[ADDR_W-1:0] = {q.upper, ctr_addr};
        OFF_WCOUNT: n.rdata = q.wcount;
        default:    n.rresp = RESP_DECERR;
      endcase
    end
  end

  // pull levels are the reset value of the strap flops [R12] [R13]
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      q <= ST_RST;
    end else begin
      q <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign S_AXI_AWREADY = ~q.aw_ok & ~q.bvalid;
  assign S_AXI_WREADY  = ~q.w_ok & ~q.bvalid;
  assign S_AXI_BVALID  = q.bvalid;
  assign S_AXI_BRESP   = q.bresp;
  assign S_AXI_ARREADY = ~q.rvalid;
  assign S_AXI_RVALID  = q.rvalid;
  assign S_AXI_RDATA   = q.rdata;
  assign S_AXI_RRESP   = q.rresp;

  assign MEM_ADDR      = {q.upper, ctr_addr}; // [R17]
  assign MEM_READ      = (q.cyc == CYC_READ);
  assign MEM_WRITE     = (q.cyc == CYC_WRITE);
  assign MEM_LANE_WE   = q.lane_we;
  assign DATA_OE       = q.oe;
  assign PIPELINED     = q.strap_s[STRAP_FLOW];    // [R8]
  assign DUAL_DESELECT = ~q.strap_s[STRAP_SDESEL]; // [R10]
  assign HIGH_DRIVE    = ~q.strap_s[STRAP_DRIVE];  // [R11]
  assign STANDBY       = q.standby;                // [R9]

endmodule : ssr_ctrl

/* verif/ssr_ctrl_chk.sv */
`timescale 1ns/1ns
module ssr_ctrl_chk
  import ssr_pkg::*;
#(
  parameter int unsigned ADDR_W = 22
) (
  input wire logic              CORE_CLK,
  input wire logic              NRST,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic              PROC_ADDR_STROBE_N,
  input wire logic              CTRL_ADDR_STROBE_N,
  input wire logic              BURST_ADVANCE_N,
  input wire logic              CHIP_SEL_N,
  input wire logic              CHIP_SEL_HI,
  input wire logic              CHIP_SEL3_N,
  input wire logic              LANE_WRITE_N,
  input wire logic              ALL_LANES_WRITE_N,
  input wire logic [LANES-1:0]  LANE_ENABLE_N,
  input wire logic              LINEAR_ORDER_N,
  input wire logic              FLOW_THROUGH_N,
  input wire logic              SINGLE_DESELECT_SEL,
  input wire logic              DRIVE_STRENGTH_SEL,
  input wire logic              SLEEP_REQ,
  input wire logic [ADDR_W-1:0] MEM_ADDR,
  input wire logic              MEM_READ,
  input wire logic              MEM_WRITE,
  input wire logic [LANES-1:0]  MEM_LANE_WE,
  input wire logic              PIPELINED,
  input wire logic              DUAL_DESELECT,
  input wire logic              HIGH_DRIVE,
  input wire logic              STANDBY
);
  // ----------------------------------------------------------------
  // memory bus relations
  // ----------------------------------------------------------------
  wire sel = !CHIP_SEL_N && CHIP_SEL_HI && !CHIP_SEL3_N;
  wire cld = !CTRL_ADDR_STROBE_N && sel && !STANDBY;
  wire pld = !PROC_ADDR_STROBE_N && sel && !STANDBY;
  wire run = (MEM_READ || MEM_WRITE) && PROC_ADDR_STROBE_N && CTRL_ADDR_STROBE_N && !STANDBY;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  addr_load_a: assert property ((cld || pld) |=> MEM_ADDR == $past(ADDR))
    else $error("burst start address not loaded");
  // order strap must be low now and two edges back, the sample the synchroniser presents
  advance_step_a: assert property (run && !BURST_ADVANCE_N && !LINEAR_ORDER_N && $past(LINEAR_ORDER_N, 2) == 1'b0
    && $past(NRST, 3) |=> MEM_ADDR[1:0] == 2'($past(MEM_ADDR[1:0]) + 2'h1)
    && MEM_ADDR[ADDR_W-1:2] == $past(MEM_ADDR[ADDR_W-1:2]))
    else $error("linear advance wrong");
  suspend_hold_a: assert property (run && BURST_ADVANCE_N |=> $stable(MEM_ADDR))
    else $error("address moved without advance");
  global_write_a: assert property (cld && !ALL_LANES_WRITE_N |=> MEM_WRITE && MEM_LANE_WE == ALL_LANES)
    else $error("global write missed lanes");
  byte_write_a: assert property (cld && ALL_LANES_WRITE_N && !LANE_WRITE_N
    |=> MEM_WRITE && MEM_LANE_WE == ~$past(LANE_ENABLE_N))
    else $error("byte write lanes wrong");
  deselect_cyc_a: assert property (!CTRL_ADDR_STROBE_N && !sel |=> !MEM_READ && !MEM_WRITE)
    else $error("access while deselected");
  flow_mode_a: assert property ($stable(FLOW_THROUGH_N) [*3] |=> PIPELINED == FLOW_THROUGH_N)
    else $error("output register mode wrong");
  drive_mode_a: assert property ($stable(DRIVE_STRENGTH_SEL) [*3] |=> HIGH_DRIVE == !DRIVE_STRENGTH_SEL)
    else $error("drive strength wrong");
  desel_mode_a: assert property ($stable(SINGLE_DESELECT_SEL) [*3] |=> DUAL_DESELECT == !SINGLE_DESELECT_SEL)
    else $error("deselect mode wrong");
  sleep_mode_a: assert property (SLEEP_REQ [*3] |=> STANDBY)
    else $error("sleep did not enter standby");
endmodule : ssr_ctrl_chk

bind ssr_ctrl ssr_ctrl_chk #(.ADDR_W(ADDR_W)) chk_i (.*);

/* verif/ssr_mem_host.sv */
`timescale 1ns/1ns
// op: 0 suspend, 1 proc read, 2 byte write, 3 global write, 4 advance, 5 deselect, 6 ctrl read
module ssr_mem_host #(
  parameter int unsigned ADDR_W = 22
) (
  input  wire logic [2:0]        op,
  input  wire logic [ADDR_W-1:0] pa,
  input  wire logic [3:0]        pl,
  output logic      [ADDR_W-1:0] ADDR,
  output logic                   PROC_ADDR_STROBE_N,
  output logic                   CTRL_ADDR_STROBE_N,
  output logic                   BURST_ADVANCE_N,
  output logic                   CHIP_SEL_N,
  output logic                   CHIP_SEL_HI,
  output logic                   CHIP_SEL3_N,
  output logic                   LANE_WRITE_N,
  output logic                   ALL_LANES_WRITE_N,
  output logic [3:0]             LANE_ENABLE_N
);
  logic strobe;
  always_comb begin
    strobe = op inside {3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
    // address is don't-care outside strobes: flip it so a held value cannot pass by luck
    ADDR = strobe ? pa : ~pa;
    PROC_ADDR_STROBE_N = op != 3'h1;
    CTRL_ADDR_STROBE_N = !(op inside {3'h2, 3'h3, 3'h5, 3'h6});
    BURST_ADVANCE_N = op != 3'h4;
    CHIP_SEL_N = !strobe;
    CHIP_SEL_HI = op != 3'h5;
    CHIP_SEL3_N = 1'b0;
    LANE_WRITE_N = op != 3'h2;
    ALL_LANES_WRITE_N = op != 3'h3;
    LANE_ENABLE_N = pl;
  end
endmodule : ssr_mem_host

/* verif/ssr_ctrl_tb.sv */
`timescale 1ns/1ns
module ssr_ctrl_tb;
  import ssr_pkg::*;
  localparam int unsigned AW = 22;
  localparam logic [AW-3:0] U = 20'h55555;
  typedef struct packed {
    logic [2:0] op;
    logic [1:0] a;
    logic [3:0] ln;
    logic [1:0] ea;
    logic       ca;
    logic       rd;
    logic       wr;
    logic [3:0] we;
  } ssr_row_s;
  localparam int NR = 11;
  localparam ssr_row_s ROWS [NR] = '{
    '{3'h1, 2'h1, 4'hF, 2'h1, 1'h1, 1'h1, 1'h0, 4'h0}, '{3'h4, 2'h0, 4'hF, 2'h2, 1'h1, 1'h1, 1'h0, 4'h0},
    '{3'h4, 2'h0, 4'hF, 2'h3, 1'h1, 1'h1, 1'h0, 4'h0}, '{3'h4, 2'h0, 4'hF, 2'h0, 1'h1, 1'h1, 1'h0, 4'h0},
    '{3'h0, 2'h0, 4'hF, 2'h0, 1'h1, 1'h1, 1'h0, 4'h0}, '{3'h3, 2'h2, 4'hF, 2'h2, 1'h1, 1'h0, 1'h1, 4'hF},
    '{3'h2, 2'h3, 4'hA, 2'h3, 1'h1, 1'h0, 1'h1, 4'h5}, '{3'h2, 2'h0, 4'hF, 2'h0, 1'h1, 1'h0, 1'h1, 4'h0},
    '{3'h5, 2'h1, 4'hF, 2'h0, 1'h0, 1'h0, 1'h0, 4'h0}, '{3'h6, 2'h2, 4'hF, 2'h2, 1'h1, 1'h1, 1'h0, 4'h0},
    '{3'h0, 2'h0, 4'hF, 2'h0, 1'h0, 1'h0, 1'h0, 4'h0}};
  logic CORE_CLK, NRST, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
  logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY, MEM_READ, MEM_WRITE, DATA_OE, PIPELINED;
  logic PROC_ADDR_STROBE_N, CTRL_ADDR_STROBE_N, BURST_ADVANCE_N, CHIP_SEL_N, CHIP_SEL_HI, CHIP_SEL3_N;
  logic LANE_WRITE_N, ALL_LANES_WRITE_N, LINEAR_ORDER_N, FLOW_THROUGH_N, SINGLE_DESELECT_SEL, DRIVE_STRENGTH_SEL;
  logic SLEEP_REQ, DUAL_DESELECT, HIGH_DRIVE, STANDBY;
  logic [3:0]    S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WSTRB, LANE_ENABLE_N, MEM_LANE_WE, pl;
  logic [1:0]    S_AXI_BRESP, S_AXI_RRESP, rsp;
  logic [31:0]   S_AXI_WDATA, S_AXI_RDATA, rd_d;
  logic [AW-1:0] ADDR, MEM_ADDR, pa;
  logic [2:0]    op;
  int            num_errors, total_checks;
  ssr_ctrl #(.ADDR_W(AW)) dut (.*);
  ssr_mem_host #(.ADDR_W(AW)) host (.*);
  initial begin
    CORE_CLK = 1'b0;
    forever #5 CORE_CLK = ~CORE_CLK;
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge CORE_CLK);
    S_AXI_AWADDR <= a; S_AXI_WDATA <= d; S_AXI_AWVALID <= 1'b1; S_AXI_WVALID <= 1'b1; S_AXI_BREADY <= 1'b1;
    do begin
      @(posedge CORE_CLK);
      if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (S_AXI_BVALID !== 1'b1);
    S_AXI_BREADY <= 1'b0;
    rsp = S_AXI_BRESP;
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a);
    @(posedge CORE_CLK);
    S_AXI_ARADDR <= a; S_AXI_ARVALID <= 1'b1; S_AXI_RREADY <= 1'b1;
    do begin
      @(posedge CORE_CLK);
      if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (S_AXI_RVALID !== 1'b1);
    S_AXI_RREADY <= 1'b0;
    rd_d = S_AXI_RDATA;
    rsp = S_AXI_RRESP;
  endtask : axi_rd
  initial begin
    #20000;
    num_errors++;
    complete_run();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    ssr_row_s r;
    NRST = 1'b0; op = 3'h0; pa = '0; pl = 4'hF; S_AXI_WSTRB = 4'hF; S_AXI_AWADDR = 4'h0; S_AXI_ARADDR = 4'h0;
    S_AXI_AWVALID = 1'b0; S_AXI_WVALID = 1'b0; S_AXI_BREADY = 1'b0; S_AXI_ARVALID = 1'b0; S_AXI_RREADY = 1'b0;
    S_AXI_WDATA = 32'h0; LINEAR_ORDER_N = 1'b1; FLOW_THROUGH_N = 1'b1; SINGLE_DESELECT_SEL = 1'b1;
    DRIVE_STRENGTH_SEL = 1'b1; SLEEP_REQ = 1'b0;
    repeat (6) @(posedge CORE_CLK);
    chk("pipelined", PIPELINED, 1'b1);
    chk("dual", DUAL_DESELECT, 1'b0);
    chk("drive", HIGH_DRIVE, 1'b0);
    chk("standby", STANDBY, 1'b0);
    NRST <= 1'b1; LINEAR_ORDER_N <= 1'b0; FLOW_THROUGH_N <= 1'b0;
    SINGLE_DESELECT_SEL <= 1'b0; DRIVE_STRENGTH_SEL <= 1'b0;
    repeat (4) @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    chk("pipelined", PIPELINED, 1'b0);
    chk("dual", DUAL_DESELECT, 1'b1);
    chk("drive", HIGH_DRIVE, 1'b1);
    for (int i = 0; i < NR; i++) begin
      @(posedge CORE_CLK);
      op <= ROWS[i].op; pa <= {U, ROWS[i].a}; pl <= ROWS[i].ln;
      @(negedge CORE_CLK);
      if (i > 0) begin
        r = ROWS[i-1];
        if (r.ca) chk("mem_addr", MEM_ADDR, {U, r.ea});
        if (r.ca) chk("lane_we", MEM_LANE_WE, r.we);
        chk("mem_read", MEM_READ, r.rd);
        chk("mem_write", MEM_WRITE, r.wr);
        // flow-through drives with the read; dual deselect holds one more cycle
        chk("data_oe", DATA_OE, r.rd | ((i > 1) ? ROWS[i-2].rd : 1'b0));
      end
    end
    @(posedge CORE_CLK);
    LINEAR_ORDER_N <= 1'b1;
    repeat (4) @(posedge CORE_CLK);
    for (int j = 0; j < 6; j++) begin
      @(posedge CORE_CLK);
      op <= (j == 0) ? 3'h1 : 3'h4; pa <= {U, 2'h1};
      @(negedge CORE_CLK);
      if (j > 0) chk("inter_addr", MEM_ADDR, {U, 2'h1 ^ 2'(j - 1)});
    end
    @(posedge CORE_CLK);
    op <= 3'h0; SLEEP_REQ <= 1'b1;
    repeat (4) @(posedge CORE_CLK);
    op <= 3'h1;
    @(posedge CORE_CLK);
    op <= 3'h0; SLEEP_REQ <= 1'b0;
    @(negedge CORE_CLK);
    chk("standby", STANDBY, 1'b1);
    chk("mem_read", MEM_READ, 1'b0);
    repeat (4) @(posedge CORE_CLK);
    axi_rd(OFF_WCOUNT);
    chk("wcount", rd_d, 32'h3);
    axi_wr(OFF_CTRL, 32'h1);
    chk("bresp", rsp, RESP_OKAY);
    repeat (3) @(posedge CORE_CLK);
    chk("standby", STANDBY, 1'b1);
    axi_rd(OFF_STATUS);
    chk("status", rd_d[5:0], 6'h21);
    axi_wr(OFF_CTRL, 32'h2);
    axi_rd(OFF_WCOUNT);
    chk("wcount", rd_d, 32'h0);
    axi_rd(4'h2);
    chk("rresp", rsp, RESP_DECERR);
    chk("rdata", rd_d, 32'h0);
    complete_run();
  end
endmodule : ssr_ctrl_tb
